//--- dpsg_pkg.sv
package dpsg_pkg;
	// Register offsets
	localparam logic [7:0] OFF_CLOCK_OUT_CTRL   = 8'h6d;
	localparam logic [7:0] OFF_GRID_C_DATA      = 8'h87;
	localparam logic [7:0] OFF_GRID_D_DATA      = 8'h88;
	localparam logic [7:0] OFF_SEGMENT_E_DATA   = 8'h89;
	localparam logic [7:0] OFF_SEGMENT_F_DATA   = 8'h8a;
	localparam logic [7:0] OFF_SEGMENT_E_DIR    = 8'h8b;
	localparam logic [7:0] OFF_SEGMENT_F_DIR    = 8'h8c;
	localparam logic [7:0] OFF_WATCHDOG_MODE    = 8'h5c;

	// Port widths
	localparam int GRID_C_W    = 8;
	localparam int GRID_D_W    = 2;
	localparam int SEGMENT_E_W = 8;
	localparam int SEGMENT_F_W = 6;

	// Reset values and fixed read values
	localparam logic [7:0] RST_PORT_DATA   = 8'h00;
	localparam logic [7:0] RST_PORT_DIR    = 8'h00;
	localparam logic       RST_CLK_OUT_EN  = 1'b0;
	localparam logic [6:0] CLK_CTRL_FIXED  = 7'h7f;
	localparam logic [7:0] RST_WATCHDOG    = 8'h80;
	localparam logic [7:0] READ_UNMAPPED   = 8'h00;
	localparam logic [7:0] READ_WRITE_ONLY = 8'h00;

	// Field positions
	localparam int CLK_OUT_EN_BIT   = 0;
	localparam int WDT_ENABLE_BIT   = 7;
	localparam int HALT_SEL_LSB     = 2;
	localparam int DRIVE_KEEP_BIT   = 1;

	// Halt mode encodings
	localparam logic [1:0] HALT_DEEP_IDLE  = 2'h0;
	localparam logic [1:0] HALT_STOP       = 2'h1;
	localparam logic [1:0] HALT_LIGHT_IDLE = 2'h3;

	// Timing
	localparam int STATE_CLK_DIV       = 2;
	localparam int HALT_ENTRY_CLOCKS   = 3;
	localparam int HALT_ENTRY_CYCLES   = HALT_ENTRY_CLOCKS;
	localparam int WARMUP_CYCLES_DEF   = 8192;
	localparam int WATCHDOG_CYCLES_DEF = 65536;

	// Wake source codes
	localparam logic [1:0] SRC_IRQ_ZERO = 2'h0;
	localparam logic [1:0] SRC_IRQ_ONE  = 2'h1;
	localparam logic [1:0] SRC_OTHER    = 2'h2;

	typedef enum logic [2:0] {
		DPSG_RUN,
		DPSG_ENTER,
		DPSG_HALT,
		DPSG_WARM,
		DPSG_FIRST,
		DPSG_SECOND
	} dpsg_state_t;
endpackage

//--- dpsg_warmup.sv
`timescale 1ns/1ps
module dpsg_warmup #(
	parameter int COUNT = dpsg_pkg::WARMUP_CYCLES_DEF
) (
	input  wire logic i_clock,
	input  wire logic i_rstn,
	input  wire logic i_ce,
	input  wire logic i_start,
	output logic      o_busy,
	output logic      o_done
);
	import dpsg_pkg::*;

	localparam int CW = $clog2(COUNT + 1);
	localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	logic          busy_r;
	logic          busy_nxt;
	logic          done_r;
	logic          done_nxt;

	always_comb begin
		cnt_nxt  = cnt_r;
		busy_nxt = busy_r;
		done_nxt = 1'b0;
		if (i_start) begin
			cnt_nxt  = '0;
			busy_nxt = 1'b1;
		end else if (busy_r) begin
			if (cnt_r == LAST) begin
				busy_nxt = 1'b0;
				done_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r + CW'(1);
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			cnt_r  <= '0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else if (i_ce) begin
			cnt_r  <= cnt_nxt;
			busy_r <= busy_nxt;
			done_r <= done_nxt;
		end
	end

	assign o_busy = busy_r;
	assign o_done = done_r;
endmodule

//--- dpsg_top.sv
`timescale 1ns/1ps
// Operation
// - Halt with stop mode raises stop
// - Drive-keep bit holds stop at zero
// - Input buffers gated by stop and drive-keep
// - Input sampled only on port register access
// - Warm-up runs on each stop-mode wake, stop released when it ends
// - Ext irq during entry held pending
// - Deep idle entry has no hold hazard
// - Higher priority of held/new served first
// - Watchdog counts from reset release
module dpsg_top
	import dpsg_pkg::*;
#(
	parameter int WARMUP_CYCLES   = dpsg_pkg::WARMUP_CYCLES_DEF,
	parameter int WATCHDOG_CYCLES = dpsg_pkg::WATCHDOG_CYCLES_DEF,
	parameter int PRIO_W          = 3
) (
	input  wire logic                         i_clock,
	input  wire logic                         i_rstn,
	input  wire logic                         i_ce,
	input  wire logic [7:0]                   i_addr,
	input  wire logic [7:0]                   i_wdata,
	input  wire logic                         i_wr,
	input  wire logic                         i_rd,
	output logic      [7:0]                   o_rdata,
	output logic      [dpsg_pkg::GRID_C_W-1:0]    o_grid_c,
	output logic      [dpsg_pkg::GRID_D_W-1:0]    o_grid_d,
	input  wire logic [dpsg_pkg::SEGMENT_E_W-1:0] i_seg_e,
	output logic      [dpsg_pkg::SEGMENT_E_W-1:0] o_seg_e,
	output logic      [dpsg_pkg::SEGMENT_E_W-1:0] o_seg_e_oe_n,
	input  wire logic [dpsg_pkg::SEGMENT_F_W-1:0] i_seg_f,
	output logic      [dpsg_pkg::SEGMENT_F_W-1:0] o_seg_f,
	output logic      [dpsg_pkg::SEGMENT_F_W-1:0] o_seg_f_oe_n,
	output logic                              o_state_clk,
	output logic                              o_clk_out,
	input  wire logic                         i_halt_exec,
	input  wire logic                         i_ext_irq_zero,
	input  wire logic [PRIO_W-1:0]            i_irq_zero_prio,
	input  wire logic                         i_ext_irq_one,
	input  wire logic [PRIO_W-1:0]            i_irq_one_prio,
	input  wire logic                         i_irq_other,
	input  wire logic [PRIO_W-1:0]            i_irq_other_prio,
	output logic                              o_stop,
	output logic                              o_input_buffer_gate,
	output logic                              o_sysclk_run,
	output logic                              o_halted,
	output logic                              o_irq_held,
	output logic                              o_serve,
	output logic      [1:0]                   o_serve_src,
	output logic                              o_wdt_expire
);
	import dpsg_pkg::*;

	localparam int WW = $clog2(WATCHDOG_CYCLES + 1);
	localparam logic [WW-1:0] WDT_LAST = WW'(WATCHDOG_CYCLES - 1);
	localparam logic [1:0] ENTRY_LAST = 2'(HALT_ENTRY_CYCLES - 1);

	// Register group
	logic [GRID_C_W-1:0]    grid_c_r, grid_c_nxt;
	logic [GRID_D_W-1:0]    grid_d_r, grid_d_nxt;
	logic [SEGMENT_E_W-1:0] seg_e_r, seg_e_nxt;
	logic [SEGMENT_F_W-1:0] seg_f_r, seg_f_nxt;
	logic [SEGMENT_E_W-1:0] dir_e_r, dir_e_nxt;
	logic [SEGMENT_F_W-1:0] dir_f_r, dir_f_nxt;
	logic                   clk_en_r, clk_en_nxt;
	logic [7:0]             wdmode_r, wdmode_nxt;
	logic [7:0]             rdata_r, rdata_nxt;
	logic [SEGMENT_E_W-1:0] pin_e;
	logic [SEGMENT_F_W-1:0] pin_f;
	logic                   drive_keep_in_stop;
	logic [1:0]             halt_mode_select;

	assign drive_keep_in_stop = wdmode_r[DRIVE_KEEP_BIT];
	assign halt_mode_select   = wdmode_r[HALT_SEL_LSB +: 2];

	// Per-bit input buffers; a cut buffer reads low
	genvar g;
	generate
		for (g = 0; g < SEGMENT_E_W; g++) begin : g_pe
			assign pin_e[g] = dir_e_r[g] ? seg_e_r[g] : (i_seg_e[g] & o_input_buffer_gate);
		end
		for (g = 0; g < SEGMENT_F_W; g++) begin : g_pf
			assign pin_f[g] = dir_f_r[g] ? seg_f_r[g] : (i_seg_f[g] & o_input_buffer_gate);
		end
	endgenerate

	always_comb begin
		grid_c_nxt = grid_c_r;
		grid_d_nxt = grid_d_r;
		seg_e_nxt  = seg_e_r;
		seg_f_nxt  = seg_f_r;
		dir_e_nxt  = dir_e_r;
		dir_f_nxt  = dir_f_r;
		clk_en_nxt = clk_en_r;
		wdmode_nxt = wdmode_r;
		rdata_nxt  = 8'h00;
		if (i_wr) begin
			case (i_addr)
				OFF_GRID_C_DATA:    grid_c_nxt = i_wdata[GRID_C_W-1:0];
				OFF_GRID_D_DATA:    grid_d_nxt = i_wdata[GRID_D_W-1:0];
				OFF_SEGMENT_E_DATA: seg_e_nxt  = i_wdata[SEGMENT_E_W-1:0];
				OFF_SEGMENT_F_DATA: seg_f_nxt  = i_wdata[SEGMENT_F_W-1:0];
				OFF_SEGMENT_E_DIR:  dir_e_nxt  = i_wdata[SEGMENT_E_W-1:0];
				OFF_SEGMENT_F_DIR:  dir_f_nxt  = i_wdata[SEGMENT_F_W-1:0];
				OFF_CLOCK_OUT_CTRL: clk_en_nxt = i_wdata[CLK_OUT_EN_BIT];
				OFF_WATCHDOG_MODE:  wdmode_nxt = i_wdata;
				default:            wdmode_nxt = wdmode_r;
			endcase
		end
		if (i_rd) begin
			// Pins are looked at only while their register is read
			case (i_addr)
				OFF_GRID_C_DATA:    rdata_nxt = 8'(grid_c_r);
				OFF_GRID_D_DATA:    rdata_nxt = 8'(grid_d_r);
				OFF_SEGMENT_E_DATA: rdata_nxt = 8'(pin_e);
				OFF_SEGMENT_F_DATA: rdata_nxt = 8'(pin_f);
				OFF_SEGMENT_E_DIR:  rdata_nxt = READ_WRITE_ONLY;
				OFF_SEGMENT_F_DIR:  rdata_nxt = READ_WRITE_ONLY;
				OFF_CLOCK_OUT_CTRL: rdata_nxt = {CLK_CTRL_FIXED, clk_en_r};
				OFF_WATCHDOG_MODE:  rdata_nxt = wdmode_r;
				default:            rdata_nxt = READ_UNMAPPED;
			endcase
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			grid_c_r <= GRID_C_W'(RST_PORT_DATA);
			grid_d_r <= GRID_D_W'(RST_PORT_DATA);
			seg_e_r  <= SEGMENT_E_W'(RST_PORT_DATA);
			seg_f_r  <= SEGMENT_F_W'(RST_PORT_DATA);
			dir_e_r  <= SEGMENT_E_W'(RST_PORT_DIR);
			dir_f_r  <= SEGMENT_F_W'(RST_PORT_DIR);
			clk_en_r <= RST_CLK_OUT_EN;
			wdmode_r <= RST_WATCHDOG;
			rdata_r  <= 8'h00;
		end else if (i_ce) begin
			grid_c_r <= grid_c_nxt;
			grid_d_r <= grid_d_nxt;
			seg_e_r  <= seg_e_nxt;
			seg_f_r  <= seg_f_nxt;
			dir_e_r  <= dir_e_nxt;
			dir_f_r  <= dir_f_nxt;
			clk_en_r <= clk_en_nxt;
			wdmode_r <= wdmode_nxt;
			rdata_r  <= rdata_nxt;
		end
	end

	assign o_rdata      = rdata_r;
	assign o_grid_c     = grid_c_r;
	assign o_grid_d     = grid_d_r;
	assign o_seg_e      = seg_e_r;
	assign o_seg_f      = seg_f_r;
	assign o_seg_e_oe_n = ~dir_e_r;
	assign o_seg_f_oe_n = ~dir_f_r;

	// State clock and clock-out pin
	logic sclk_r, sclk_nxt;

	always_comb begin
		sclk_nxt = ~sclk_r;
	end

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			sclk_r <= 1'b0;
		end else if (i_ce && o_sysclk_run) begin
			sclk_r <= sclk_nxt;
		end
	end

	assign o_state_clk = sclk_r;
	// Gated pin is glitch-free since both inputs are registered
	assign o_clk_out   = sclk_r & clk_en_r;

	// Watchdog, enabled out of reset
	logic [WW-1:0] wdt_r, wdt_nxt;
	logic          wdt_exp_r, wdt_exp_nxt;

	always_comb begin
		wdt_nxt     = wdt_r;
		wdt_exp_nxt = 1'b0;
		if (!wdmode_r[WDT_ENABLE_BIT] || (i_wr && i_addr == OFF_WATCHDOG_MODE)) begin
			wdt_nxt = '0;
		end else if (wdt_r == WDT_LAST) begin
			wdt_nxt     = '0;
			wdt_exp_nxt = 1'b1;
		end else begin
			wdt_nxt = wdt_r + WW'(1);
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			wdt_r     <= '0;
			wdt_exp_r <= 1'b0;
		end else if (i_ce) begin
			wdt_r     <= wdt_nxt;
			wdt_exp_r <= wdt_exp_nxt;
		end
	end

	assign o_wdt_expire = wdt_exp_r;

	// Halt sequencing
	dpsg_state_t       st_r, st_nxt;
	logic [1:0]        mode_r, mode_nxt;
	logic [1:0]        ent_r, ent_nxt;
	logic              stop_r, stop_nxt;
	logic              held_r, held_nxt;
	logic [1:0]        held_src_r, held_src_nxt;
	logic [PRIO_W-1:0] held_pri_r, held_pri_nxt;
	logic [1:0]        wake_src_r, wake_src_nxt;
	logic [PRIO_W-1:0] wake_pri_r, wake_pri_nxt;
	logic              serve_r, serve_nxt;
	logic [1:0]        ssrc_r, ssrc_nxt;
	logic              warm_start;
	logic              warm_busy;
	logic              warm_done;
	logic              ext_any;
	logic [1:0]        ext_src;
	logic [PRIO_W-1:0] ext_pri;
	logic              held_first;

	// Zero wins when both external lines fire together
	assign ext_any    = i_ext_irq_zero | i_ext_irq_one;
	assign ext_src    = i_ext_irq_zero ? SRC_IRQ_ZERO : SRC_IRQ_ONE;
	assign ext_pri    = i_ext_irq_zero ? i_irq_zero_prio : i_irq_one_prio;
	assign held_first = held_r && (held_pri_r > wake_pri_r);

	always_comb begin
		st_nxt       = st_r;
		mode_nxt     = mode_r;
		ent_nxt      = ent_r;
		stop_nxt     = stop_r;
		held_nxt     = held_r;
		held_src_nxt = held_src_r;
		held_pri_nxt = held_pri_r;
		wake_src_nxt = wake_src_r;
		wake_pri_nxt = wake_pri_r;
		serve_nxt    = 1'b0;
		ssrc_nxt     = ssrc_r;
		warm_start   = 1'b0;
		case (st_r)
			DPSG_RUN: begin
				if (i_halt_exec) begin
					st_nxt   = DPSG_ENTER;
					mode_nxt = halt_mode_select;
					ent_nxt  = 2'h0;
					stop_nxt = (halt_mode_select == HALT_STOP) && !drive_keep_in_stop;
				end
			end
			DPSG_ENTER: begin
				if (mode_r == HALT_DEEP_IDLE && (ext_any || i_irq_other)) begin
					// Deep idle wakes cleanly even mid-entry
					st_nxt       = DPSG_FIRST;
					wake_src_nxt = ext_any ? ext_src : SRC_OTHER;
					wake_pri_nxt = ext_any ? ext_pri : i_irq_other_prio;
				end else begin
					if (ext_any && !held_r) begin
						held_nxt     = 1'b1;
						held_src_nxt = ext_src;
						held_pri_nxt = ext_pri;
					end
					if (ent_r == ENTRY_LAST) begin
						st_nxt = DPSG_HALT;
					end else begin
						ent_nxt = ent_r + 2'h1;
					end
				end
			end
			DPSG_HALT: begin
				if (ext_any || i_irq_other) begin
					wake_src_nxt = ext_any ? ext_src : SRC_OTHER;
					wake_pri_nxt = ext_any ? ext_pri : i_irq_other_prio;
					if (mode_r == HALT_STOP) begin
						st_nxt     = DPSG_WARM;
						warm_start = 1'b1;
					end else begin
						st_nxt = DPSG_FIRST;
					end
				end
			end
			DPSG_WARM: begin
				// System clock withheld until the count ends
				if (warm_done) begin
					st_nxt   = DPSG_FIRST;
					stop_nxt = 1'b0;
				end
			end
			DPSG_FIRST: begin
				serve_nxt = 1'b1;
				ssrc_nxt  = held_first ? held_src_r : wake_src_r;
				st_nxt    = held_r ? DPSG_SECOND : DPSG_RUN;
			end
			DPSG_SECOND: begin
				serve_nxt = 1'b1;
				ssrc_nxt  = held_first ? wake_src_r : held_src_r;
				held_nxt  = 1'b0;
				st_nxt    = DPSG_RUN;
			end
			default: begin
				st_nxt   = DPSG_RUN;
				stop_nxt = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			st_r       <= DPSG_RUN;
			mode_r     <= HALT_DEEP_IDLE;
			ent_r      <= 2'h0;
			stop_r     <= 1'b0;
			held_r     <= 1'b0;
			held_src_r <= SRC_IRQ_ZERO;
			held_pri_r <= '0;
			wake_src_r <= SRC_IRQ_ZERO;
			wake_pri_r <= '0;
			serve_r    <= 1'b0;
			ssrc_r     <= SRC_IRQ_ZERO;
		end else if (i_ce) begin
			st_r       <= st_nxt;
			mode_r     <= mode_nxt;
			ent_r      <= ent_nxt;
			stop_r     <= stop_nxt;
			held_r     <= held_nxt;
			held_src_r <= held_src_nxt;
			held_pri_r <= held_pri_nxt;
			wake_src_r <= wake_src_nxt;
			wake_pri_r <= wake_pri_nxt;
			serve_r    <= serve_nxt;
			ssrc_r     <= ssrc_nxt;
		end
	end

	dpsg_warmup #(
		.COUNT (WARMUP_CYCLES)
	) u_warmup (
		.i_clock (i_clock),
		.i_rstn  (i_rstn),
		.i_ce    (i_ce),
		.i_start (warm_start),
		.o_busy  (warm_busy),
		.o_done  (warm_done)
	);

	assign o_stop              = stop_r;
	assign o_input_buffer_gate = ~(stop_r & ~drive_keep_in_stop);
	assign o_halted            = (st_r == DPSG_HALT) || (st_r == DPSG_WARM);
	assign o_sysclk_run        = !(mode_r == HALT_STOP && st_r == DPSG_HALT) && !warm_busy;
	assign o_irq_held          = held_r;
	assign o_serve             = serve_r;
	assign o_serve_src         = ssrc_r;
endmodule

//--- dpsg_monitor.sv
`timescale 1ns/1ps
module dpsg_monitor #(
	parameter int WARMUP_CYCLES = 8
) (
	input wire logic       i_clock,
	input wire logic       i_rstn,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic       i_wr,
	input wire logic       i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic [7:0] o_seg_e_oe_n,
	input wire logic       o_state_clk,
	input wire logic       o_clk_out,
	input wire logic       i_halt_exec,
	input wire logic       o_stop,
	input wire logic       o_input_buffer_gate,
	input wire logic       o_sysclk_run,
	input wire logic       o_halted,
	input wire logic       o_irq_held,
	input wire logic       o_serve
);
	// Shadow of mode bits, rebuilt from bus writes
	logic [1:0]  mode_r;
	logic        keep_r;
	logic        en_r;
	logic        stop_seen_r;
	logic [15:0] low_cnt_r;
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			mode_r      <= 2'h0;
			keep_r      <= 1'b0;
			en_r        <= 1'b0;
			stop_seen_r <= 1'b0;
			low_cnt_r   <= 16'h0;
		end else begin
			if (i_wr && i_addr == 8'h5c) begin
				mode_r <= i_wdata[3:2];
				keep_r <= i_wdata[1];
			end
			if (i_wr && i_addr == 8'h6d) begin
				en_r <= i_wdata[0];
			end
			stop_seen_r <= o_stop | (stop_seen_r & ~o_sysclk_run);
			low_cnt_r   <= o_sysclk_run ? 16'h0 : low_cnt_r + 16'h1;
		end
	end
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rstn);
	sequence s_entry;
		!o_halted [*3] ##1 o_halted;
	endsequence
	sequence s_pair;
		o_serve ##1 o_serve;
	endsequence
	chk_stop_rise: assert property (
		i_halt_exec && !o_halted && mode_r == 2'h1 && !keep_r |=> o_stop)
		else $error("stop missing after halt");
	chk_keep_low: assert property (
		keep_r |-> !o_stop)
		else $error("stop high with drive keep");
	chk_gate_stop: assert property (
		o_input_buffer_gate == !o_stop)
		else $error("input gate disagrees with stop");
	chk_warm_len: assert property (
		$rose(o_sysclk_run) && stop_seen_r |-> low_cnt_r >= WARMUP_CYCLES)
		else $error("clock resumed before warm-up");
	chk_halt_entry: assert property (
		i_halt_exec && !o_halted && !o_stop && !o_irq_held && mode_r != 2'h0 |=> s_entry)
		else $error("halt entry not three cycles");
	chk_serve_pair: assert property (
		o_serve && o_irq_held |-> s_pair)
		else $error("held interrupt not served next");
	chk_dir_oe: assert property (
		i_wr && i_addr == 8'h8b |=> o_seg_e_oe_n == ~$past(i_wdata))
		else $error("enable not inverse of direction");
	chk_dir_read: assert property (
		i_rd && (i_addr == 8'h8b || i_addr == 8'h8c) |=> o_rdata == 8'h00)
		else $error("direction register readable");
	chk_ctl_read: assert property (
		i_rd && i_addr == 8'h6d |=> o_rdata == {7'h7f, en_r})
		else $error("clock control read wrong");
	chk_clk_gate: assert property (
		o_clk_out |-> o_state_clk && en_r)
		else $error("clock out while disabled");
	// Reset in the antecedent keeps the release edge out of the check
	chk_sclk_toggle: assert property (
		o_sysclk_run && i_rstn |=> o_state_clk != $past(o_state_clk))
		else $error("state clock not halving system clock");
endmodule

//--- dpsg_vfd_model.sv
`timescale 1ns/1ps
module dpsg_vfd_model (
	input  wire logic       i_clock,
	input  wire logic [7:0] i_seg_e,
	input  wire logic [7:0] i_seg_e_oe_n,
	input  wire logic [5:0] i_seg_f,
	input  wire logic [5:0] i_seg_f_oe_n,
	output logic      [7:0] o_pin_e,
	output logic      [5:0] o_pin_f
);
	// Released lines move every cycle so a stale value never passes
	logic [7:0] float_r = 8'h5a;
	always @(negedge i_clock) begin
		float_r <= {float_r[6:0], float_r[7] ^ float_r[5] ^ float_r[4] ^ float_r[3]};
	end
	assign o_pin_e = (i_seg_e & ~i_seg_e_oe_n) | (float_r & i_seg_e_oe_n);
	assign o_pin_f = (i_seg_f & ~i_seg_f_oe_n) | (~float_r[5:0] & i_seg_f_oe_n);
endmodule

//--- dpsg_top_test.sv
`timescale 1ns/1ps
module dpsg_top_test;
	logic       i_clock, i_rstn, i_ce, i_wr, i_rd, i_halt_exec;
	logic       i_ext_irq_zero, i_ext_irq_one, i_irq_other;
	logic [7:0] i_addr, i_wdata, o_rdata, o_grid_c, i_seg_e, o_seg_e, o_seg_e_oe_n;
	logic [1:0] o_grid_d, o_serve_src;
	logic [5:0] i_seg_f, o_seg_f, o_seg_f_oe_n;
	logic [2:0] i_irq_zero_prio, i_irq_one_prio, i_irq_other_prio;
	logic       o_state_clk, o_clk_out, o_stop, o_input_buffer_gate, o_sysclk_run;
	logic       o_halted, o_irq_held, o_serve, o_wdt_expire;
	int         n_fail, n_checks;
	logic [7:0] d, got_e, c, g, se, de, en;
	logic [5:0] got_f, sf, df;
	logic [2:0] ph, po;
	logic [1:0] hs;
	time        t0;
	dpsg_top #(.WARMUP_CYCLES(8), .WATCHDOG_CYCLES(32)) i_dut (.*);
	dpsg_vfd_model i_vfd (.i_clock(i_clock), .i_seg_e(o_seg_e), .i_seg_e_oe_n(o_seg_e_oe_n),
		.i_seg_f(o_seg_f), .i_seg_f_oe_n(o_seg_f_oe_n), .o_pin_e(i_seg_e), .o_pin_f(i_seg_f));
	initial begin
		i_clock = 1'b0;
		forever #20 i_clock = ~i_clock;
	end
	function automatic logic [7:0] exp_seg(input logic [7:0] lat, dir, pin, input logic gt);
		return (dir & lat) | (~dir & pin & {8{gt}});
	endfunction
	// Equal priorities go to the waking source
	function automatic logic [7:0] first_src(input logic [2:0] hp, wp, input logic [1:0] src);
		return (hp > wp) ? {6'h0, src} : 8'h02;
	endfunction
	task automatic complete_run();
		$display("checks=%0d fails=%0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, dat);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= dat;
		@(posedge i_clock);
		i_wr <= 1'b0;
		// Idle edge, so back-to-back writes never drive the strobe twice in one step
		@(posedge i_clock);
	endtask
	// Pins captured at the edge that takes the read
	task automatic rd(input logic [7:0] a);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		got_e = i_seg_e;
		got_f = i_seg_f;
		i_rd <= 1'b0;
		// Read data stand only in the cycle after the strobe
		#1 d = o_rdata;
		@(posedge i_clock);
	endtask
	task automatic pulse(input int k);
		case (k)
			0: i_halt_exec <= 1'b1;
			1: i_ext_irq_zero <= 1'b1;
			2: i_ext_irq_one <= 1'b1;
			default: i_irq_other <= 1'b1;
		endcase
		@(posedge i_clock);
		{i_halt_exec, i_ext_irq_zero, i_ext_irq_one, i_irq_other} <= 4'h0;
	endtask
	task automatic wait_on(input int k);
		for (int n = 0; n < 60; n++) begin
			@(posedge i_clock);
			#1;
			if ((k == 0 && o_serve === 1'b1) || (k == 1 && o_halted === 1'b1) ||
				(k == 2 && o_wdt_expire === 1'b1)) return;
		end
		n_fail++;
		$display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
		complete_run();
	endtask
	initial begin
		{i_rstn, i_wr, i_rd, i_halt_exec, i_ext_irq_zero, i_ext_irq_one, i_irq_other} = 7'h0;
		i_ce = 1'b1;
		{i_addr, i_wdata} = 16'h0;
		{i_irq_zero_prio, i_irq_one_prio, i_irq_other_prio} = 9'h0;
		n_fail = 0;
		n_checks = 0;
		void'($urandom(87));
		repeat (6) @(posedge i_clock);
		i_rstn <= 1'b1;
		@(posedge i_clock);
		chk(o_seg_e_oe_n, 8'hff);
		rd(8'h6d);
		chk(d, 8'hfe);
		rd(8'h8b);
		chk(d, 8'h00);
		rd(8'h89);
		chk(d, exp_seg(8'h00, 8'h00, got_e, 1'b1));
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			{c, g, se, de, en} = {8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom)};
			{sf, df} = {6'($urandom), i == 0 ? 6'h3f : 6'($urandom)};
			wr(8'h87, c);
			wr(8'h88, g);
			wr(8'h89, se);
			wr(8'h8a, {2'h0, sf});
			wr(8'h8b, de);
			wr(8'h8c, {2'h0, df});
			wr(8'h6d, en);
			#1 chk(o_grid_c, c);
			chk({6'h0, o_grid_d}, g & 8'h03);
			chk(o_seg_e_oe_n, ~de);
			chk({2'h0, o_seg_f_oe_n}, {2'h0, ~df});
			chk(o_seg_e, se);
			chk({2'h0, o_seg_f}, {2'h0, sf});
			rd(8'h89);
			chk(d, exp_seg(se, de, got_e, 1'b1));
			rd(8'h8a);
			chk(d, exp_seg({2'h0, sf}, {2'h0, df}, {2'h0, got_f}, 1'b1));
			rd(8'h8c);
			chk(d, 8'h00);
			rd(8'h6d);
			chk(d, {7'h7f, en[0]});
		end
		$display("test ports done");
		wr(8'h8b, 8'h00);
		wr(8'h5c, 8'h84);
		pulse(0);
		#1 chk({7'h0, o_stop}, 8'h01);
		wait_on(1);
		chk({7'h0, o_input_buffer_gate}, 8'h00);
		pulse(3);
		wait_on(0);
		chk({6'h0, o_serve_src}, 8'h02);
		chk({o_stop, o_sysclk_run}, 8'h01);
		$display("test stop done");
		repeat (3) @(posedge i_clock);
		wr(8'h5c, 8'h86);
		pulse(0);
		wait_on(1);
		chk({o_stop, o_input_buffer_gate}, 8'h01);
		pulse(3);
		wait_on(0);
		$display("test keep done");
		for (int i = 0; i < 3; i++) begin
			{ph, po} = {3'($urandom), 3'($urandom)};
			if (i == 2) po = ph;
			hs = (i == 1) ? 2'h1 : 2'h0;
			{i_irq_zero_prio, i_irq_one_prio, i_irq_other_prio} <= {ph, ph, po};
			repeat (3) @(posedge i_clock);
			wr(8'h5c, 8'h8c);
			pulse(0);
			@(posedge i_clock);
			pulse(32'(hs) + 1);
			wait_on(1);
			chk({7'h0, o_irq_held}, 8'h01);
			pulse(3);
			wait_on(0);
			chk({6'h0, o_serve_src}, first_src(ph, po, hs));
			@(posedge i_clock);
			#1 chk({7'h0, o_serve}, 8'h01);
			chk({6'h0, o_serve_src}, first_src(ph, po, hs) == 8'h02 ? {6'h0, hs} : 8'h02);
		end
		$display("test hold done");
		repeat (3) @(posedge i_clock);
		wr(8'h5c, 8'h80);
		pulse(0);
		@(posedge i_clock);
		pulse(1);
		wait_on(0);
		chk({o_irq_held, o_serve_src}, 8'h00);
		$display("test deep idle done");
		wait_on(2);
		t0 = $time;
		wait_on(2);
		chk(8'(($time - t0) / 40), 8'h20);
		$display("test watchdog done");
		complete_run();
	end
endmodule
bind dpsg_top dpsg_monitor #(.WARMUP_CYCLES(WARMUP_CYCLES)) i_mon (.*);
